// *** logic/tfs_status_regs.sv ***
// Sticky alarm flags and readout registers of the temperature and fan monitor
`timescale 1ns/1ps
`include "tfs_regs.svh"

module tfs_status_regs
    import tfs_pkg::*;
#(
    parameter bit DUTY_VARIANT = 1'b0,
    parameter bit ALERT_RESPONSE = 1'b1
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register read port
    input wire logic rdEn,
    input wire logic [7:0] rdAddr,
    output logic [7:0] rdData,
    output logic rdValid,
    // Alert response completion, one-cycle pulse
    input wire logic alertDone,
    // Monitoring cycle results
    input wire logic cycleDone,
    input wire tfs_meas_s meas,
    input wire tfs_limits_s limits,
    input wire logic diodeFault,
    input wire logic pwmFull,
    input wire logic cfgRemoteEn,
    // Alarm line: pin level and own drive
    input wire logic thermal_alarm_line,
    input wire logic alarmDriveLow
);

    tfs_state_s s_q;
    tfs_state_s s_d;

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    logic remoteOk;
    logic [7:0] setPri;
    logic [7:0] setSec;
    logic [7:0] clrPri;
    logic [7:0] clrSec;
    logic [7:0] clrAlert;
    logic [7:0] readMux;

    // Remote channel enabled while cfgRemoteEn is set, unless the diode failed at the first cycle after reset
    assign remoteOk = cfgRemoteEn & ~s_q.remoteDisabled;

    // Set terms, evaluated when a monitoring cycle completes, except the drive-based speed alarm and the external pull
    always_comb
    begin
        setPri = 8'h00;
        setSec = 8'h00;
        setPri[`TFS_PRI_LOCAL_LOW] = cycleDone &&
            ($signed(meas.localTemp) < $signed(limits.localLow));
        setPri[`TFS_PRI_LOCAL_HIGH] = cycleDone &&
            ($signed(meas.localTemp) > $signed(limits.localHigh));
        setPri[`TFS_PRI_DIODE_ERR] = cycleDone && diodeFault;
        setPri[`TFS_PRI_REMOTE_THERMAL_ALARM_LINE] = cycleDone && remoteOk &&
            ($signed(meas.remoteTemp) > $signed(limits.remoteTherm));
        setPri[`TFS_PRI_REMOTE_LOW] = cycleDone && remoteOk &&
            ($signed(meas.remoteTemp) < $signed(limits.remoteLow));
        setPri[`TFS_PRI_FAN_FAULT] = cycleDone &&
            (meas.fanSpeed > limits.tachHigh);
        if (DUTY_VARIANT)
        begin
            // Only the start of a full-duty spell raises the flag
            setPri[`TFS_PRI_SPEED_ALARM] = cycleDone && pwmFull && !s_q.pwmFullPrev;
        end
        else
        begin
            setPri[`TFS_PRI_SPEED_ALARM] = alarmDriveLow;
        end
        // Line low while this device did not drive it means an external pull; the
        // drive copy is delayed like the pin, so a release never looks external
        setSec[`TFS_SEC_EXT_THERMAL_ALARM_LINE] = !s_q.lineSync2 && !s_q.driveDly2;
        setSec[`TFS_SEC_LOCAL_THERMAL_ALARM_LINE] = cycleDone &&
            ($signed(meas.localTemp) > $signed(limits.localTherm));
    end

    // ----------------------------------------------------------------
    // Read decode and clear terms
    // ----------------------------------------------------------------
    always_comb
    begin
        unique case (rdAddr)
            `TFS_ADDR_FLAGS_PRI: readMux = s_q.flagsPri;
            `TFS_ADDR_FLAGS_SEC: readMux = s_q.flagsSec;
            `TFS_ADDR_FRACTION: readMux = s_q.fraction;
            `TFS_ADDR_FAN_SPEED: readMux = s_q.fanSpeed;
            default: readMux = 8'h00;
        endcase
    end

    // Only bits present in the returned data are cleared
    assign clrPri = (rdEn && rdAddr == `TFS_ADDR_FLAGS_PRI) ? s_q.flagsPri : 8'h00;
    assign clrSec = (rdEn && rdAddr == `TFS_ADDR_FLAGS_SEC) ? s_q.flagsSec : 8'h00;
    assign clrAlert = (ALERT_RESPONSE && alertDone) ?
        (s_q.flagsPri & `TFS_PRI_ALERT_MASK) : 8'h00;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        // Set wins over a clear in the same cycle
        s_d.flagsPri = (s_q.flagsPri & ~clrPri & ~clrAlert) | setPri;
        s_d.flagsSec = (s_q.flagsSec & ~clrSec) | setSec;
        s_d.rdData = rdEn ? readMux : s_q.rdData;
        s_d.rdValid = rdEn;
        s_d.lineSync1 = thermal_alarm_line;
        s_d.lineSync2 = s_q.lineSync1;
        // Own drive delayed to line up with the synchronised pin
        s_d.driveDly1 = alarmDriveLow;
        s_d.driveDly2 = s_q.driveDly1;
        if (cycleDone)
        begin
            s_d.fraction = {meas.localFrac, 2'b00, meas.remoteFrac};
            s_d.fanSpeed = meas.fanSpeed;
            s_d.pwmFullPrev = pwmFull;
            s_d.firstCycle = 1'b0;
            if (s_q.firstCycle)
            begin
                s_d.remoteDisabled = diodeFault;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q.flagsPri <= `TFS_RST_FLAGS;
            s_q.flagsSec <= `TFS_RST_FLAGS;
            s_q.fraction <= `TFS_RST_FRACTION;
            s_q.fanSpeed <= `TFS_RST_FAN_SPEED;
            s_q.rdData <= 8'h00;
            s_q.rdValid <= 1'b0;
            s_q.lineSync1 <= 1'b1;
            s_q.lineSync2 <= 1'b1;
            s_q.driveDly1 <= 1'b0;
            s_q.driveDly2 <= 1'b0;
            s_q.pwmFullPrev <= 1'b0;
            s_q.remoteDisabled <= 1'b0;
            s_q.firstCycle <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign rdData = s_q.rdData;
    assign rdValid = s_q.rdValid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // Local-low condition at a cycle raises the flag, even during a read
    chk_local_low_set: assert property (
        cycleDone && $signed(meas.localTemp) < $signed(limits.localLow)
        |=> s_q.flagsPri[`TFS_PRI_LOCAL_LOW])
        else $error("local low flag not set");

    // Primary read with no new cycle leaves local-low clear
    chk_read_clears: assert property (
        rdEn && rdAddr == `TFS_ADDR_FLAGS_PRI && !cycleDone
        |=> !s_q.flagsPri[`TFS_PRI_LOCAL_LOW] && rdValid
        && rdData[`TFS_PRI_LOCAL_LOW] == $past(s_q.flagsPri[`TFS_PRI_LOCAL_LOW]))
        else $error("local low flag not cleared by read");

    // Local-high condition raises bit 6
    chk_local_high_set: assert property (
        cycleDone && $signed(meas.localTemp) > $signed(limits.localHigh)
        |=> s_q.flagsPri[`TFS_PRI_LOCAL_HIGH])
        else $error("local high flag not set");

    // Alert response clears the temperature-limit flags
    chk_alert_clears: assert property (
        ALERT_RESPONSE && alertDone && !cycleDone
        |=> (s_q.flagsPri & `TFS_PRI_ALERT_MASK) == 8'h00)
        else $error("alert response did not clear flags");

    // Diode fault raises bit 5
    chk_diode_set: assert property (
        cycleDone && diodeFault |=> s_q.flagsPri[`TFS_PRI_DIODE_ERR])
        else $error("diode error flag not set");

    // Remote alarm limit raises bit 4 only while remote is enabled
    chk_remote_thermal_alarm_line: assert property (
        cycleDone && $signed(meas.remoteTemp) > $signed(limits.remoteTherm)
        |=> s_q.flagsPri[`TFS_PRI_REMOTE_THERMAL_ALARM_LINE] == $past(remoteOk)
        || $past(s_q.flagsPri[`TFS_PRI_REMOTE_THERMAL_ALARM_LINE]))
        else $error("remote alarm flag wrong");

    // Remote low raises bit 3 when enabled
    chk_remote_low: assert property (
        cycleDone && remoteOk && $signed(meas.remoteTemp) < $signed(limits.remoteLow)
        |=> s_q.flagsPri[`TFS_PRI_REMOTE_LOW])
        else $error("remote low flag not set");

    // Stalled fan raises the fan-fault flag
    chk_fan_fault: assert property (
        cycleDone && meas.fanSpeed > limits.tachHigh
        |=> s_q.flagsPri[`TFS_PRI_FAN_FAULT])
        else $error("fan fault flag not set");

    // Full duty spell raises bit 0 only at its start
    chk_duty_once: assert property (
        DUTY_VARIANT && s_q.pwmFullPrev && !s_q.flagsPri[`TFS_PRI_SPEED_ALARM]
        && !alarmDriveLow
        |=> !s_q.flagsPri[`TFS_PRI_SPEED_ALARM])
        else $error("speed alarm re-set during same spell");

    // Driven-low alarm line raises bit 0
    chk_speed_alarm: assert property (
        !DUTY_VARIANT && alarmDriveLow |=> s_q.flagsPri[`TFS_PRI_SPEED_ALARM])
        else $error("speed alarm not set");

    // External pull-down, after two synchroniser stages, raises secondary bit 7
    chk_ext_pull: assert property (
        !thermal_alarm_line && !alarmDriveLow ##1 !alarmDriveLow ##1 !alarmDriveLow
        |=> s_q.flagsSec[`TFS_SEC_EXT_THERMAL_ALARM_LINE])
        else $error("external alarm pull not flagged");

    // Local alarm limit raises secondary bit 6 and low bits stay zero
    chk_local_thermal_alarm_line: assert property (
        cycleDone && $signed(meas.localTemp) > $signed(limits.localTherm)
        |=> s_q.flagsSec[`TFS_SEC_LOCAL_THERMAL_ALARM_LINE] && s_q.flagsSec[5:0] == 6'h00)
        else $error("local alarm flag wrong");

    // Fraction register layout
    chk_fraction: assert property (
        cycleDone ##1 rdEn && rdAddr == `TFS_ADDR_FRACTION
        |=> rdData[4:3] == 2'b00 && rdData[2:0] == $past(meas.remoteFrac, 2))
        else $error("fraction layout wrong");

    // Fan-speed register follows the latest measurement
    chk_fan_reading: assert property (
        cycleDone |=> s_q.fanSpeed == $past(meas.fanSpeed))
        else $error("fan speed reading not updated");

    // Without a cycle, the local-low and remote-low flags never rise
    chk_cycle_only: assert property (
        !cycleDone |=> !$rose(s_q.flagsPri[`TFS_PRI_LOCAL_LOW])
        && !$rose(s_q.flagsPri[`TFS_PRI_REMOTE_LOW]))
        else $error("flag set outside monitoring cycle");

    // Fraction register takes both fractions and zero filler at each cycle
    chk_frac_capture: assert property (
        cycleDone |=> s_q.fraction[7:5] == $past(meas.localFrac)
        && s_q.fraction[4:3] == 2'b00 && s_q.fraction[2:0] == $past(meas.remoteFrac))
        else $error("fraction bits not captured");

    // Own drive of the alarm line never counts as an external pull
    chk_own_drive: assert property (
        alarmDriveLow |-> ##2 !setSec[`TFS_SEC_EXT_THERMAL_ALARM_LINE])
        else $error("own alarm drive flagged as external");

    // A diode fault at the first cycle after reset disables the remote flags
    chk_diode_gate: assert property (
        cycleDone && s_q.firstCycle |=> s_q.remoteDisabled == $past(diodeFault))
        else $error("remote disable not taken at first cycle");

    // Unused secondary bits always stay zero
    chk_sec_unused: assert property (
        s_q.flagsSec[5:0] == 6'h00)
        else $error("unused secondary bits set");

    // Without the alert capability a completed alert response changes no flag
    chk_alert_ignored: assert property (
        !ALERT_RESPONSE && alertDone && !rdEn && !cycleDone && !alarmDriveLow
        |=> s_q.flagsPri == $past(s_q.flagsPri))
        else $error("alert response acted without capability");

endmodule

// *** logic/tfs_regs.svh ***
// Register offsets, field positions and reset values of the thermal status readout
`ifndef TFS_REGS_SVH
`define TFS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TFS_ADDR_FLAGS_PRI 8'h02
`define TFS_ADDR_FLAGS_SEC 8'h03
`define TFS_ADDR_FRACTION 8'h06
`define TFS_ADDR_FAN_SPEED 8'h08

// ----------------------------------------------------------------
// Primary flag field positions
// ----------------------------------------------------------------
`define TFS_PRI_LOCAL_LOW 7
`define TFS_PRI_LOCAL_HIGH 6
`define TFS_PRI_DIODE_ERR 5
`define TFS_PRI_REMOTE_THERMAL_ALARM_LINE 4
`define TFS_PRI_REMOTE_LOW 3
`define TFS_PRI_FAN_FAULT 1
`define TFS_PRI_SPEED_ALARM 0
`define TFS_PRI_ALERT_MASK 8'hC8

// ----------------------------------------------------------------
// Secondary flag and fraction field positions
// ----------------------------------------------------------------
`define TFS_SEC_EXT_THERMAL_ALARM_LINE 7
`define TFS_SEC_LOCAL_THERMAL_ALARM_LINE 6
`define TFS_FRAC_LOCAL_LSB 5
`define TFS_FRAC_REMOTE_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TFS_RST_FLAGS 8'h00
`define TFS_RST_FRACTION 8'h00
`define TFS_RST_FAN_SPEED 8'hFF

`endif

// *** logic/tfs_pkg.sv ***
// Types shared by the thermal status readout
package tfs_pkg;

    // One completed measurement set
    typedef struct packed {
        logic [7:0] localTemp;
        logic [2:0] localFrac;
        logic [7:0] remoteTemp;
        logic [2:0] remoteFrac;
        logic [7:0] fanSpeed;
    } tfs_meas_s;

    // Programmed limits from the configuration block
    typedef struct packed {
        logic [7:0] localHigh;
        logic [7:0] localLow;
        logic [7:0] localTherm;
        logic [7:0] remoteLow;
        logic [7:0] remoteTherm;
        logic [7:0] tachHigh;
    } tfs_limits_s;

    // Whole state of the readout block
    typedef struct packed {
        logic [7:0] flagsPri;
        logic [7:0] flagsSec;
        logic [7:0] fraction;
        logic [7:0] fanSpeed;
        logic [7:0] rdData;
        logic rdValid;
        logic lineSync1;
        logic lineSync2;
        logic driveDly1;
        logic driveDly2;
        logic pwmFullPrev;
        logic remoteDisabled;
        logic firstCycle;
    } tfs_state_s;

endpackage

// *** dv/tfs_host_model.sv ***
// Register-reading host model facing the thermal status readout
`timescale 1ns/1ps

module tfs_host_model
    import tfs_pkg::*;
(
    // Clock
    input wire logic clock,
    // Read answer from the device
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    // Requests to the device
    output logic rdEn,
    output logic [7:0] rdAddr,
    output logic alertDone
);

    // Idle request lines from time zero
    initial
    begin
        rdEn = 1'b0;
        rdAddr = 8'h00;
        alertDone = 1'b0;
    end

    // One-cycle read pulse, then a bounded wait for the answer
    task automatic readReg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        int n;
        @(posedge clock);
        #2;
        rdEn = 1'b1;
        rdAddr = addr;
        @(posedge clock);
        #2;
        rdEn = 1'b0;
        ok = 1'b0;
        data = 8'h00;
        // The answer stands from the edge that took the request to the next one
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (rdValid === 1'b1)
            begin
                ok = 1'b1;
                data = rdData;
            end
            else
            begin
                @(posedge clock);
                #2;
            end
        end
    endtask

    // Completion of an alert response transaction, one-cycle pulse
    task automatic alertPulse();
        @(posedge clock);
        #2;
        alertDone = 1'b1;
        @(posedge clock);
        #2;
        alertDone = 1'b0;
    endtask

endmodule

// *** dv/thermal_fan_status_readout_tb.sv ***
// Self-checking bench of the thermal status readout
`timescale 1ns/1ps
`include "tfs_regs.svh"

module thermal_fan_status_readout_tb;
    import tfs_pkg::*;

    typedef struct packed {
        tfs_meas_s meas;
        logic diode;
        logic [7:0] pri;
        logic [7:0] sec;
        logic [7:0] frac;
    } tfs_row_s;

    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic cycleDone = 1'b0;
    tfs_meas_s meas = '0;
    tfs_limits_s limits = {8'h3C, 8'h00, 8'h46, 8'h00, 8'h64, 8'h80};
    logic diodeFault = 1'b0;
    logic pwmFull = 1'b0;
    logic cfgRemoteEn = 1'b1;
    logic thermal_alarm_line = 1'b1;
    logic alarmDriveLow = 1'b0;
    logic rdEn;
    logic alertDone;
    logic rdValid;
    logic [7:0] rdAddr;
    logic [7:0] rdData;
    logic rdEnVar;
    logic [7:0] rdAddrVar;
    logic [7:0] rdDataVar;
    logic rdValidVar;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    tfs_row_s rows [0:8];
    tfs_meas_s m;

    // Clock of 25 ns period
    always #12.5 clock = ~clock;

    tfs_status_regs tfs_status_regs_i (
        .clock(clock), .rst_b(rst_b), .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData),
        .rdValid(rdValid), .alertDone(alertDone), .cycleDone(cycleDone), .meas(meas),
        .limits(limits), .diodeFault(diodeFault), .pwmFull(pwmFull),
        .cfgRemoteEn(cfgRemoteEn), .thermal_alarm_line(thermal_alarm_line),
        .alarmDriveLow(alarmDriveLow)
    );

    tfs_host_model tfs_host_model_i (
        .clock(clock), .rdData(rdData), .rdValid(rdValid), .rdEn(rdEn), .rdAddr(rdAddr),
        .alertDone(alertDone)
    );

    // Duty variant without alert capability: same inputs, own reader
    tfs_status_regs #(
        .DUTY_VARIANT(1'b1),
        .ALERT_RESPONSE(1'b0)
    ) tfs_status_regs_var_i (
        .clock(clock), .rst_b(rst_b), .rdEn(rdEnVar), .rdAddr(rdAddrVar), .rdData(rdDataVar),
        .rdValid(rdValidVar), .alertDone(alertDone), .cycleDone(cycleDone), .meas(meas),
        .limits(limits), .diodeFault(diodeFault), .pwmFull(pwmFull),
        .cfgRemoteEn(cfgRemoteEn), .thermal_alarm_line(thermal_alarm_line),
        .alarmDriveLow(alarmDriveLow)
    );

    tfs_host_model tfs_host_model_var_i (
        .clock(clock), .rdData(rdDataVar), .rdValid(rdValidVar), .rdEn(rdEnVar),
        .rdAddr(rdAddrVar), .alertDone()
    );

    // Cut a hang short
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            results();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %02X seen %02X", name, exp, seen);
        end
    endtask

    // Read one register and compare it
    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        logic ok;
        tfs_host_model_i.readReg(addr, data, ok);
        check("read answered", {7'h00, ok}, 8'h01);
        check($sformatf("reg %02X", addr), data, exp);
    endtask

    // Read one register of the duty variant and compare it
    task automatic rdChkVar(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        logic ok;
        tfs_host_model_var_i.readReg(addr, data, ok);
        check("variant read answered", {7'h00, ok}, 8'h01);
        check($sformatf("variant reg %02X", addr), data, exp);
    endtask

    // One monitoring cycle result
    task automatic measure(input tfs_meas_s mv);
        @(posedge clock);
        #2;
        meas = mv;
        cycleDone = 1'b1;
        @(posedge clock);
        #2;
        cycleDone = 1'b0;
    endtask

    // Reset values of all registers and of an unmapped place
    task automatic resetChk();
        rdChk(`TFS_ADDR_FLAGS_PRI, `TFS_RST_FLAGS);
        rdChk(`TFS_ADDR_FLAGS_SEC, `TFS_RST_FLAGS);
        rdChk(`TFS_ADDR_FRACTION, `TFS_RST_FRACTION);
        rdChk(`TFS_ADDR_FAN_SPEED, 8'hFF);
        rdChk(8'h05, 8'h00);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        rows = '{
            '{'{8'h1E, 3'h5, 8'h1E, 3'h3, 8'h40}, 1'b0, 8'h00, 8'h00, 8'hA3},
            '{'{8'hF6, 3'h0, 8'h1E, 3'h0, 8'h40}, 1'b0, 8'h80, 8'h00, 8'h00},
            '{'{8'h3C, 3'h7, 8'h64, 3'h7, 8'h80}, 1'b0, 8'h00, 8'h00, 8'hE7},
            '{'{8'h3D, 3'h0, 8'h1E, 3'h0, 8'h40}, 1'b0, 8'h40, 8'h00, 8'h00},
            '{'{8'h47, 3'h0, 8'h1E, 3'h0, 8'h40}, 1'b0, 8'h40, 8'h40, 8'h00},
            '{'{8'h1E, 3'h0, 8'h65, 3'h0, 8'h40}, 1'b0, 8'h10, 8'h00, 8'h00},
            '{'{8'h1E, 3'h0, 8'hFB, 3'h0, 8'h40}, 1'b0, 8'h08, 8'h00, 8'h00},
            '{'{8'h1E, 3'h0, 8'h1E, 3'h0, 8'h81}, 1'b0, 8'h02, 8'h00, 8'h00},
            '{'{8'h1E, 3'h0, 8'h1E, 3'h0, 8'h40}, 1'b1, 8'h20, 8'h00, 8'h00}
        };
        repeat (16) @(posedge clock);
        #2 rst_b = 1'b1;
        resetChk();
        for (int i = 0; i <= 8; i++)
        begin
            diodeFault = rows[i].diode;
            measure(rows[i].meas);
            rdChk(`TFS_ADDR_FLAGS_PRI, rows[i].pri);
            rdChk(`TFS_ADDR_FLAGS_PRI, 8'h00);
            rdChk(`TFS_ADDR_FLAGS_SEC, rows[i].sec);
            rdChk(`TFS_ADDR_FLAGS_SEC, 8'h00);
            rdChk(`TFS_ADDR_FRACTION, rows[i].frac);
            rdChk(`TFS_ADDR_FAN_SPEED, rows[i].meas.fanSpeed);
            diodeFault = 1'b0;
        end
        // Persisting low temperature sets the flag again each cycle
        m = rows[1].meas;
        measure(m);
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h80);
        measure(m);
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h80);
        // Read in the same cycle as a new result keeps the new flag
        fork
            measure(m);
            rdChk(`TFS_ADDR_FLAGS_PRI, 8'h00);
        join
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h80);
        // Fraction read right behind a new result already shows the new bits
        fork
            measure(rows[2].meas);
            begin
                @(posedge clock);
                rdChk(`TFS_ADDR_FRACTION, rows[2].frac);
            end
        join
        // Alert response clears limit flags but not the remote alarm flag
        m = '{8'hF6, 3'h0, 8'h65, 3'h0, 8'h40};
        measure(m);
        tfs_host_model_i.alertPulse();
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h10);
        // Remote channel disabled hides remote flags
        @(posedge clock);
        #2 cfgRemoteEn = 1'b0;
        measure(m);
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h80);
        @(posedge clock);
        #2 cfgRemoteEn = 1'b1;
        // External pull on the alarm line, then own drive of it
        thermal_alarm_line = 1'b0;
        repeat (4) @(posedge clock);
        #2 thermal_alarm_line = 1'b1;
        repeat (4) @(posedge clock);
        rdChk(`TFS_ADDR_FLAGS_SEC, 8'h80);
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h00);
        rdChk(`TFS_ADDR_FLAGS_SEC, 8'h00);
        @(posedge clock);
        #2 thermal_alarm_line = 1'b0;
        alarmDriveLow = 1'b1;
        repeat (4) @(posedge clock);
        // Own drive ends and the pin rises at once, as through its pull-up
        #2 thermal_alarm_line = 1'b1;
        alarmDriveLow = 1'b0;
        repeat (4) @(posedge clock);
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h01);
        rdChk(`TFS_ADDR_FLAGS_SEC, 8'h00);
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h00);
        // Duty variant: gathered flags stay, the alert response is ignored
        rdChkVar(`TFS_ADDR_FLAGS_PRI, 8'hFA);
        // Full duty raises bit 0 once per spell, only in the duty variant
        pwmFull = 1'b1;
        measure(rows[0].meas);
        rdChkVar(`TFS_ADDR_FLAGS_PRI, 8'h01);
        rdChk(`TFS_ADDR_FLAGS_PRI, 8'h00);
        measure(rows[0].meas);
        rdChkVar(`TFS_ADDR_FLAGS_PRI, 8'h00);
        pwmFull = 1'b0;
        measure(rows[0].meas);
        pwmFull = 1'b1;
        measure(rows[0].meas);
        rdChkVar(`TFS_ADDR_FLAGS_PRI, 8'h01);
        pwmFull = 1'b0;
        // Second reset from non-default contents
        measure('{8'h47, 3'h7, 8'h1E, 3'h7, 8'h81});
        @(posedge clock);
        #2 rst_b = 1'b0;
        repeat (3) @(posedge clock);
        #2 rst_b = 1'b1;
        resetChk();
        results();
    end

endmodule
